// >>> verilog/csi_rx_core.sv
`timescale 1ns/1ps
`default_nettype none
module csi_rx_core
  import csi_rx_pkg::*;
#(
  parameter int FIFO_AW = FIFO_DEPTH_LOG2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic [1:0] i_lane_count,
  input wire logic [BUS_W-1:0] i_lane_data,
  input wire logic [EV_N-1:0] i_int_mask,
  input wire logic i_status_rdclr,
  input wire logic i_err_count_clr,
  output logic [EV_N-1:0] o_int_status,
  output logic o_irq,
  output logic [CNT_W-1:0] o_err_count,
  output logic [31:0] o_version,
  output logic [15:0] o_maker_identification,
  output pix_group_t o_pix,
  input wire logic i_rd_clk,
  input wire logic i_rd_ready,
  output logic o_rd_valid,
  output pix_group_t o_rd_pix
);
  localparam int DEPTH = 1 << FIFO_AW;

  ////////////////////////////////////////////////////////////////////////////
  // reset release, one synchroniser per clock domain
  logic [1:0] rst_sync_r;
  logic [1:0] rd_rst_sync_r;
  logic rst_n;
  logic rd_rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge i_rd_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_rst_sync_r <= 2'h0;
    end else begin
      rd_rst_sync_r <= {rd_rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];
  assign rd_rst_n = rd_rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // per-lane sync detection and descrambling
  function automatic logic [31:0] prbs_step(input logic [15:0] state);
    logic [15:0] s;
    logic [15:0] ks;
    s = state;
    ks = 16'h0000;
    for (int b = 0; b < LANE_W; b++) begin
      ks[b] = s[0];
      s = s[0] ? ((s >> 1) ^ PRBS_POLY) : (s >> 1);
    end
    prbs_step = {s, ks};
  endfunction

  pkt_state_t state_r;
  pkt_state_t state_nxt;
  logic [MAX_LANES-1:0] lane_active;
  logic [MAX_LANES-1:0] lane_sync;
  logic [BUS_W-1:0] plain;
  logic all_sync;
  logic any_sync;
  logic in_pkt;

  assign in_pkt = (state_r != ST_IDLE);

  for (genvar l = 0; l < MAX_LANES; l++) begin : g_lane
    logic [15:0] lfsr_r;
    logic [31:0] step;
    assign lane_active[l] = (2'(l) <= i_lane_count);
    assign lane_sync[l] = lane_active[l] && (i_lane_data[l*LANE_W +: LANE_W] == SYNC_WORD);
    assign step = prbs_step(lfsr_r);
    assign plain[l*LANE_W +: LANE_W] = i_lane_data[l*LANE_W +: LANE_W] ^ step[15:0];
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        lfsr_r <= PRBS_SEED;
      end else if (i_ce) begin
        if (!in_pkt) begin
          lfsr_r <= PRBS_SEED;
        end else begin
          lfsr_r <= step[31:16];
        end
      end
    end
  end

  assign all_sync = i_enable && (lane_sync == lane_active);
  assign any_sync = i_enable && (|lane_sync);

  ////////////////////////////////////////////////////////////////////////////
  // packet parsing: sync, format word, byte count, payload
  logic [7:0] fmt_r;
  logic [15:0] remain_r;
  logic [15:0] remain_nxt;
  logic [3:0] lane_bytes;
  logic [15:0] avail;
  logic fmt_ok;
  logic data_cycle;

  assign lane_bytes = {1'b0, i_lane_count, 1'b0} + 4'h2;
  assign avail = (remain_r < {12'h000, lane_bytes}) ? remain_r : {12'h000, lane_bytes};
  assign fmt_ok = (fmt_r == FMT_RAW8) || (fmt_r == FMT_RAW16);
  // pixels stop at once when reception is switched off mid-packet
  assign data_cycle = (state_r == ST_DATA) && i_enable;
  assign remain_nxt = remain_r - avail;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (all_sync) begin
          state_nxt = ST_TYPE;
        end
      end
      ST_TYPE: begin
        state_nxt = ST_COUNT;
      end
      ST_COUNT: begin
        state_nxt = (plain[15:0] == 16'h0000) ? ST_IDLE : ST_DATA;
      end
      ST_DATA: begin
        if (remain_nxt == 16'h0000) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (!i_enable) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      fmt_r <= 8'h00;
      remain_r <= 16'h0000;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (state_r == ST_TYPE) begin
        fmt_r <= plain[7:0];
      end
      if (state_r == ST_COUNT) begin
        remain_r <= plain[15:0];
      end else if (data_cycle) begin
        remain_r <= remain_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // format conversion into one pixel group per core clock
  pix_group_t group;

  for (genvar p = 0; p < PIX_MAX; p++) begin : g_pix
    logic [15:0] wide;
    // upper half has no 16-bit source; its valid falls out of the byte count
    if (p < PIX_MAX / 2) begin : g_wide
      assign wide = plain[p*16 +: 16];
    end else begin : g_none
      assign wide = 16'h0000;
    end
    always_comb begin
      if (fmt_r == FMT_RAW16) begin
        group.pix[p] = wide;
        group.valid[p] = data_cycle && (16'(2*p + 1) < avail);
      end else begin
        group.pix[p] = {8'h00, plain[p*8 +: 8]};
        group.valid[p] = data_cycle && (fmt_r == FMT_RAW8) && (16'(p) < avail);
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pix <= '0;
    end else if (i_ce) begin
      o_pix <= group;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output fifo; write side on the core clock, read side on the readout clock
  pix_group_t mem [DEPTH];
  logic [FIFO_AW:0] wbin_r;
  logic [FIFO_AW:0] wgray_r;
  logic [FIFO_AW:0] rbin_r;
  logic [FIFO_AW:0] rgray_r;
  logic [FIFO_AW:0] rg_s1_r;
  logic [FIFO_AW:0] rg_s2_r;
  logic [FIFO_AW:0] wg_s1_r;
  logic [FIFO_AW:0] wg_s2_r;
  logic [FIFO_AW:0] wbin_inc;
  logic [FIFO_AW:0] rbin_inc;
  logic full;
  logic push;
  logic pop;

  assign wbin_inc = wbin_r + 1'b1;
  assign rbin_inc = rbin_r + 1'b1;
  assign full = (wgray_r == {~rg_s2_r[FIFO_AW:FIFO_AW-1], rg_s2_r[FIFO_AW-2:0]});
  assign push = i_ce && (|o_pix.valid) && !full;
  assign o_rd_valid = (rgray_r != wg_s2_r);
  assign pop = o_rd_valid && i_rd_ready;
  assign o_rd_pix = mem[rbin_r[FIFO_AW-1:0]];

  // a full fifo cannot stall the lanes, so the group is dropped and flagged
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else if (i_ce) begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
      if (push) begin
        wbin_r <= wbin_inc;
        wgray_r <= wbin_inc ^ (wbin_inc >> 1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wbin_r[FIFO_AW-1:0]] <= o_pix;
    end
  end

  always_ff @(posedge i_rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      if (pop) begin
        rbin_r <= rbin_inc;
        rgray_r <= rbin_inc ^ (rbin_inc >> 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, sticky status, interrupt and error counter
  logic [EV_N-1:0] events;
  logic [EV_N-1:0] status_nxt;
  logic err_event;

  assign events[EV_DONE] = i_ce && data_cycle && (remain_nxt == 16'h0000);
  assign events[EV_SYNC] = i_ce && !in_pkt && any_sync && !all_sync;
  assign events[EV_FMT] = i_ce && (state_r == ST_COUNT) && !fmt_ok;
  assign events[EV_OVF] = i_ce && (|o_pix.valid) && full;
  assign err_event = |events[EV_OVF:EV_SYNC];
  // set wins over a read-and-clear in the same cycle
  assign status_nxt = ((i_status_rdclr && i_ce) ? STATUS_RST : o_int_status) | events;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_int_status <= STATUS_RST;
      o_irq <= 1'b0;
      o_err_count <= ERR_CNT_RST;
    end else if (i_ce) begin
      o_int_status <= status_nxt;
      o_irq <= |(status_nxt & i_int_mask);
      if (i_err_count_clr) begin
        o_err_count <= ERR_CNT_RST;
      end else if (err_event && (o_err_count != {CNT_W{1'b1}})) begin
        o_err_count <= o_err_count + 1'b1;
      end
    end
  end

  // constants need no clock, so a slower register clock may sample them
  assign o_version = VERSION_CODE;
  assign o_maker_identification = MAKER_CODE;
endmodule
`default_nettype wire

// >>> inc/csi_rx_pkg.sv
package csi_rx_pkg;
  localparam int LANE_W = 16;
  localparam int MAX_LANES = 4;
  localparam int PIX_MAX = 8;
  localparam int PIX_W = 16;
  localparam int BUS_W = LANE_W * MAX_LANES;
  localparam int CNT_W = 16;
  localparam int FIFO_DEPTH_LOG2 = 4;
  // raw word on every active lane that opens a packet; never scrambled
  localparam logic [15:0] SYNC_WORD = 16'h00b8;
  localparam logic [15:0] PRBS_SEED = 16'hffff;
  // galois form of x^16 + x^14 + x^13 + x^11 + 1
  localparam logic [15:0] PRBS_POLY = 16'hb400;
  localparam logic [7:0] FMT_RAW8 = 8'h2a;
  localparam logic [7:0] FMT_RAW16 = 8'h2e;
  localparam int EV_N = 4;
  localparam int EV_DONE = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_FMT = 2;
  localparam int EV_OVF = 3;
  localparam logic [EV_N-1:0] STATUS_RST = 4'h0;
  localparam logic [CNT_W-1:0] ERR_CNT_RST = 16'h0000;
  // arbitrary values
  localparam logic [31:0] VERSION_CODE = 32'h0001_0000;
  localparam logic [15:0] MAKER_CODE = 16'h0a5a;

  typedef struct packed {
    logic [PIX_MAX-1:0] valid;
    logic [PIX_MAX-1:0][PIX_W-1:0] pix;
  } pix_group_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TYPE = 4'b0010,
    ST_COUNT = 4'b0100,
    ST_DATA = 4'b1000
  } pkt_state_t;
endpackage

// >>> bench/csi_rx_chk.sv
`timescale 1ns/1ps
`default_nettype none
module csi_rx_chk
  import csi_rx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic [EV_N-1:0] i_int_mask,
  input wire logic i_status_rdclr,
  input wire logic i_err_count_clr,
  input wire logic [EV_N-1:0] o_int_status,
  input wire logic o_irq,
  input wire logic [CNT_W-1:0] o_err_count,
  input wire logic [31:0] o_version,
  input wire logic [15:0] o_maker_identification,
  input wire pix_group_t o_pix,
  input wire logic i_rd_clk,
  input wire logic i_rd_ready,
  input wire logic o_rd_valid,
  input wire pix_group_t o_rd_pix
);
  a_irq_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce |=> o_irq == |(o_int_status & $past(i_int_mask))) else $error("irq level");
  a_status_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_status_rdclr |=> (o_int_status & $past(o_int_status)) == $past(o_int_status))
    else $error("status lost");
  a_err_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_err_count_clr |=> o_err_count == 16'h0) else $error("count not cleared");
  a_err_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_err_count_clr |=> o_err_count - $past(o_err_count) <= 1) else $error("count step");
  a_err_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_err_count != $past(o_err_count) && !$past(i_err_count_clr) |-> (o_int_status & 4'he) != 0)
    else $error("count without event");
  a_pix_packed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_pix.valid & (o_pix.valid + 8'h1)) == 8'h0) else $error("valid gap");
  a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_enable |=> o_pix.valid == 8'h0) else $error("pixels while off");
  a_ident_const: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_version == VERSION_CODE && o_maker_identification == MAKER_CODE) else $error("ident");
  a_rd_hold: assert property (@(posedge i_rd_clk) disable iff (!i_rst_n)
    o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_pix)) else $error("head lost");
endmodule
`default_nettype wire

// >>> bench/lane_src.sv
`timescale 1ns/1ps
`default_nettype none
module lane_src
  import csi_rx_pkg::*;
(
  input wire logic i_clk,
  output logic [BUS_W-1:0] o_data
);
  // idle words keep bit 15 set so no lane can look like a sync word
  initial o_data = {4{16'h8000}};
  function automatic logic [15:0] step(inout logic [15:0] s);
    logic [15:0] k;
    for (int i = 0; i < 16; i++) begin
      k[i] = s[0];
      s = (s >> 1) ^ (s[0] ? PRBS_POLY : 16'h0000);
    end
    return k;
  endfunction
  task automatic raw(input logic [63:0] w);
    @(negedge i_clk) o_data = w;
  endtask
  task automatic send(input logic [7:0] f, input int n, input logic [1:0] lc,
                      input logic [7:0] b[$]);
    logic [15:0] s;
    logic [63:0] w;
    int nb;
    s = PRBS_SEED;
    nb = 2 * lc + 2;
    raw({4{SYNC_WORD}});
    for (int c = 1; c <= 2 + (n + nb - 1) / nb; c++) begin
      w = {$urandom, $urandom};
      if (c == 1) w[7:0] = f;
      if (c == 2) w[15:0] = 16'(n);
      for (int j = 0; c > 2 && j < nb; j++) w[8*j+:8] = b[(c-3)*nb+j];
      raw(w ^ {4{step(s)}});
    end
    raw({4{16'h8000}} | {$urandom, $urandom});
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import csi_rx_pkg::*;
;
  logic i_clk = 0, i_rd_clk = 0, i_rst_n = 0, i_ce = 1, i_enable = 0, i_rd_ready = 0;
  logic i_status_rdclr = 0, i_err_count_clr = 0, stall = 0, o_irq, o_rd_valid;
  logic [1:0] i_lane_count = 2'h3;
  logic [EV_N-1:0] i_int_mask = 4'h0, o_int_status;
  wire logic [BUS_W-1:0] i_lane_data;
  logic [CNT_W-1:0] o_err_count, ec;
  logic [31:0] o_version;
  logic [15:0] o_maker_identification;
  pix_group_t o_pix, o_rd_pix, qp[$], qr[$];
  int miscompares = 0, cmp_count = 0, cyc = 0, room = 1000;
  csi_rx_core #(.FIFO_AW(2)) csi_rx_core_inst (.*);
  lane_src lane_src_inst (.i_clk(i_clk), .o_data(i_lane_data));
  // 20 MHz core, 15 ns readout clock
  initial forever #25 i_clk = ~i_clk;
  initial begin
    #4;
    forever #7.5 i_rd_clk = ~i_rd_clk;
  end
  //////////////////////////////////////////////////
  task automatic check(input logic [135:0] seen, input logic [135:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic pix_group_t clean(input pix_group_t g);
    for (int j = 0; j < PIX_MAX; j++) if (!g.valid[j]) g.pix[j] = '0;
    return g;
  endfunction
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (i_rst_n && o_pix.valid !== 8'h0)
      check(clean(o_pix), qp.size() ? qp.pop_front() : '1);
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  always @(posedge i_rd_clk)
    if (o_rd_valid === 1'b1 && i_rd_ready)
      check(clean(o_rd_pix), qr.size() ? qr.pop_front() : '1);
  always @(negedge i_rd_clk) i_rd_ready <= !stall && $urandom_range(1);
  //////////////////////////////////////////////////
  task automatic clr(input bit e);
    @(negedge i_clk) {i_err_count_clr, i_status_rdclr} = e ? 2'b10 : 2'b01;
    @(negedge i_clk) {i_err_count_clr, i_status_rdclr} = 2'b00;
  endtask
  task automatic pkt(input logic [7:0] f, input int n);
    logic [7:0] b[$];
    pix_group_t g;
    int w;
    w = 2 * (i_lane_count + 1);
    for (int i = 0; i < n; i++) b.push_back(8'($urandom_range(255)));
    for (int c = 0; c < n && f inside {FMT_RAW8, FMT_RAW16}; c += w) begin
      g = '0;
      for (int j = 0; j < w; j++)
        if (f == FMT_RAW8) begin
          g.valid[j] = 1'b1;
          g.pix[j] = {8'h00, b[c+j]};
        end else if (j % 2) begin
          g.valid[j/2] = 1'b1;
          g.pix[j/2] = {b[c+j], b[c+j-1]};
        end
      qp.push_back(g);
      if (room > 0) qr.push_back(g);
      room--;
    end
    lane_src_inst.send(f, n, i_lane_count, b);
    repeat (3) @(negedge i_clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && qr.size() != 0; i++) @(negedge i_clk);
    repeat (5) @(negedge i_clk);
  endtask
  //////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2c0e));
    repeat (10) @(negedge i_clk);
    i_rst_n = 1;
    repeat (4) @(negedge i_clk);
    i_enable = 1;
    check(o_version, VERSION_CODE);
    check(o_maker_identification, MAKER_CODE);
    for (int l = 0; l < 4; l++)
      for (int f = 0; f < 2; f++) begin
        i_lane_count = 2'(l);
        i_int_mask = 4'($urandom);
        clr(0);
        pkt(f ? FMT_RAW16 : FMT_RAW8, 2 * (l + 1) * $urandom_range(1, 3));
        check(o_int_status, 4'h1);
        check(o_irq, i_int_mask[EV_DONE]);
      end
    $display("test formats done");
    i_int_mask = 4'hf;
    ec = o_err_count;
    pkt(8'h00, 8);
    check(o_int_status[EV_FMT], 1'b1);
    lane_src_inst.raw({48'h8001_8002_8003, SYNC_WORD});
    lane_src_inst.raw({4{16'h8000}});
    repeat (2) @(negedge i_clk);
    check(o_int_status[EV_SYNC], 1'b1);
    check(o_err_count, ec + 16'h2);
    // clock enable low must freeze the sticky status against a clear
    i_ce = 0;
    clr(0);
    check(o_int_status[EV_SYNC], 1'b1);
    i_ce = 1;
    clr(0);
    @(negedge i_clk);
    check({o_int_status, o_irq}, 5'h0);
    clr(1);
    check(o_err_count, 16'h0);
    $display("test events done");
    drain();
    stall = 1;
    room = 4;
    repeat (3) @(negedge i_clk);
    pkt(FMT_RAW8, 40);
    check(o_int_status[EV_OVF], 1'b1);
    check(o_err_count, 16'h1);
    stall = 0;
    drain();
    check(qr.size() + qp.size(), 0);
    $display("test overflow done");
    final_report();
  end
endmodule
bind csi_rx_core csi_rx_chk csi_rx_chk_inst (.*);
`default_nettype wire
